// ### hdl/evt_pll_pkg.sv
// constants for the event flag and pll configuration register bank
package evt_pll_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int FLAG_W = 2 * DATA_W;

	localparam logic [ADDR_W-1:0] OFF_IRQ_EN_CLK = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EN_PAT = 8'h05;
	localparam logic [ADDR_W-1:0] OFF_FLAGS_CLK = 8'h06;
	localparam logic [ADDR_W-1:0] OFF_FLAGS_PAT = 8'h07;
	localparam logic [ADDR_W-1:0] OFF_CLK_RX = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_PLL_CTRL = 8'h0A;
	localparam logic [ADDR_W-1:0] OFF_PLL_LOOP = 8'h0C;

	// implemented bits; the rest read as zero
	localparam logic [DATA_W-1:0] MASK_IRQ_EN_CLK = 8'hF3;
	localparam logic [DATA_W-1:0] MASK_IRQ_EN_PAT = 8'h1C;
	localparam logic [DATA_W-1:0] MASK_FLAGS_CLK = 8'hF3;
	localparam logic [DATA_W-1:0] MASK_FLAGS_PAT = 8'h1C;
	localparam logic [DATA_W-1:0] MASK_CLK_RX = 8'hF0;
	localparam logic [DATA_W-1:0] MASK_PLL_CTRL = 8'hFF;
	localparam logic [DATA_W-1:0] MASK_PLL_LOOP = 8'hDF;

	localparam logic [DATA_W-1:0] RST_IRQ_EN = 8'h00;
	localparam logic [DATA_W-1:0] RST_CLK_RX = 8'h30;
	localparam logic [DATA_W-1:0] RST_PLL_CTRL = 8'h40;
	localparam logic [DATA_W-1:0] RST_PLL_LOOP = 8'hD1;
	localparam logic [FLAG_W-1:0] RST_FLAGS = 16'h0000;

	// bit positions in the clock/sync/fifo flag byte
	localparam int BIT_PLL_LOCK_LOST = 7;
	localparam int BIT_PLL_LOCKED = 6;
	localparam int BIT_SYNC_LOST = 5;
	localparam int BIT_SYNC_LOCKED = 4;
	localparam int BIT_FIFO_WARN1 = 1;
	localparam int BIT_FIFO_WARN2 = 0;
	// bit positions in the pattern flag byte
	localparam int BIT_AVG_PASS = 4;
	localparam int BIT_AVG_FAIL = 3;
	localparam int BIT_SMP_FAIL = 2;
	// configuration fields
	localparam int BIT_DUTY_CONV = 7;
	localparam int BIT_DUTY_REF = 6;
	localparam int BIT_CROSS_CONV = 5;
	localparam int BIT_CROSS_REF = 4;
	localparam int BIT_PLL_EN = 7;
	localparam int BIT_MAN_BAND_EN = 6;
	localparam int BAND_MSB = 5;
	localparam int BW_MSB = 7;
	localparam int BW_LSB = 6;
	localparam int CP_MSB = 4;

	localparam int FIFO_GAP_WARN1 = 1;
	localparam int FIFO_GAP_WARN2 = 2;
	localparam int AVG_CLEAR_PAIRS = 8;
	localparam int PAIR_CNT_W = 4;
endpackage

// ### hdl/flag_if.sv
// set, clear and state of the sticky event flags
interface flag_if #(parameter int W = 16);
	logic [W-1:0] set;
	logic [W-1:0] clr;
	logic [W-1:0] flags;
	modport bank (input set, input clr, output flags);
	modport user (output set, output clr, input flags);
endinterface

// ### hdl/event_flag_bank.sv
// bank of sticky write-one-to-clear flags
module event_flag_bank
	import evt_pll_pkg::*;
#(
	parameter int W = 16
)
(
	input wire logic clock_i,
	input wire logic rstn_i,
	flag_if.bank fl
);
	logic [W-1:0] flags_reg;

	// set after clear: an event in the clearing cycle survives
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			flags_reg <= W'(RST_FLAGS);
		else
			flags_reg <= (flags_reg & ~fl.clr) | fl.set; // RULE_09
	end

	assign fl.flags = flags_reg;
endmodule

// ### hdl/event_pll_regs.sv
// event flag, interrupt enable, clock receiver and pll setting registers
// Contract
// RULE_01 - software writes zero to unused enable bits (the bench writes random values to bits 3,2 of the clock enable register)
// RULE_02 - enable bits 4,3 gate averaged pass/fail
// RULE_03 - enable bit 2 gates sample fail, resets zero
// RULE_04 - pll lock lost flag latches until cleared
// RULE_05 - pll locked flag reads one when locked
// RULE_06 - sync lost flag latches until cleared
// RULE_07 - sync locked flag sets on alignment
// RULE_08 - fifo warnings at pointer gap one, two
// RULE_09 - writing one clears a flag, zero keeps
// RULE_10 - averaged pass flag latches on match
// RULE_11 - averaged fail self-clears after eight good pairs
// RULE_12 - sample fail flag latches on mismatch
// RULE_13 - clock receiver corrections, crossing bits reset one
// RULE_14 - pll enable bit uses reference clock
// RULE_15 - manual band bit selects written band
// RULE_16 - loop bandwidth field resets to narrowest
// RULE_17 - charge pump field resets to 10001
// RULE_18 - first enable register mirrors first flag byte
// RULE_19 - interrupt while any enabled flag set
module event_pll_regs
	import evt_pll_pkg::*;
#(
	parameter int PTR_W = 3
)
(
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [evt_pll_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [evt_pll_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	output logic [evt_pll_pkg::DATA_W-1:0] reg_rdata_o,
	input wire logic pll_locked_i,
	input wire logic sync_aligned_i,
	input wire logic [PTR_W-1:0] fifo_gap_i,
	input wire logic avg_pass_i,
	input wire logic avg_fail_i,
	input wire logic iq_pair_valid_i,
	input wire logic smp_fail_i,
	output logic irq_o,
	output logic conv_duty_corr_o,
	output logic ref_duty_corr_o,
	output logic conv_cross_corr_o,
	output logic ref_cross_corr_o,
	output logic pll_enable_o,
	output logic manual_band_en_o,
	output logic [evt_pll_pkg::BAND_MSB:0] manual_oscillator_band_o,
	output logic [evt_pll_pkg::BW_MSB-evt_pll_pkg::BW_LSB:0] loop_bw_o,
	output logic [evt_pll_pkg::CP_MSB:0] charge_pump_o
);
	import evt_pll_pkg::*;

	function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		wr_hit = wr && (a == off);
	endfunction

	logic [DATA_W-1:0] irq_en_clk_reg;
	logic [DATA_W-1:0] irq_en_pat_reg;
	logic [DATA_W-1:0] clk_rx_reg;
	logic [DATA_W-1:0] pll_ctrl_reg;
	logic [DATA_W-1:0] pll_loop_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic irq_reg;
	logic pll_locked_prev_reg;
	logic sync_aligned_prev_reg;
	logic [PAIR_CNT_W-1:0] pair_cnt_reg;
	logic avg_autoclr;
	logic [FLAG_W-1:0] flags;
	logic irq_any;

	flag_if #(.W(FLAG_W)) fl ();

	event_flag_bank #(.W(FLAG_W)) u_flags (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.fl(fl.bank)
	);

	assign flags = fl.flags;

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pll_locked_prev_reg <= 1'b0;
			sync_aligned_prev_reg <= 1'b0;
		end
		else
		begin
			pll_locked_prev_reg <= pll_locked_i;
			sync_aligned_prev_reg <= sync_aligned_i;
		end
	end

	// good pairs counted only while the fail flag stands; any fail restarts
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			pair_cnt_reg <= '0;
		else if (avg_fail_i || !flags[DATA_W + BIT_AVG_FAIL] || avg_autoclr)
			pair_cnt_reg <= '0;
		else if (iq_pair_valid_i)
			pair_cnt_reg <= pair_cnt_reg + 1'b1;
	end

	assign avg_autoclr = flags[DATA_W + BIT_AVG_FAIL] && iq_pair_valid_i && !avg_fail_i
		&& (pair_cnt_reg == PAIR_CNT_W'(AVG_CLEAR_PAIRS - 1)); // RULE_11

	always_comb
	begin
		fl.set = '0;
		fl.set[BIT_PLL_LOCK_LOST] = pll_locked_prev_reg && !pll_locked_i; // RULE_04
		fl.set[BIT_PLL_LOCKED] = pll_locked_i; // RULE_05
		fl.set[BIT_SYNC_LOST] = sync_aligned_prev_reg && !sync_aligned_i; // RULE_06
		fl.set[BIT_SYNC_LOCKED] = sync_aligned_i; // RULE_07
		fl.set[BIT_FIFO_WARN1] = (fifo_gap_i == PTR_W'(FIFO_GAP_WARN1)); // RULE_08
		fl.set[BIT_FIFO_WARN2] = (fifo_gap_i == PTR_W'(FIFO_GAP_WARN2)); // RULE_08
		fl.set[DATA_W + BIT_AVG_PASS] = avg_pass_i; // RULE_10
		fl.set[DATA_W + BIT_AVG_FAIL] = avg_fail_i; // RULE_11
		fl.set[DATA_W + BIT_SMP_FAIL] = smp_fail_i; // RULE_12
	end

	always_comb
	begin
		fl.clr = '0;
		if (wr_hit(reg_wr_i, reg_addr_i, OFF_FLAGS_CLK))
			fl.clr[DATA_W-1:0] = reg_wdata_i & MASK_FLAGS_CLK; // RULE_09
		if (wr_hit(reg_wr_i, reg_addr_i, OFF_FLAGS_PAT))
			fl.clr[FLAG_W-1:DATA_W] = reg_wdata_i & MASK_FLAGS_PAT; // RULE_09
		if (avg_autoclr)
			fl.clr[DATA_W + BIT_AVG_FAIL] = 1'b1; // RULE_11
	end

	// unused enable bits are not stored, so stray ones cannot raise requests
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			irq_en_clk_reg <= RST_IRQ_EN;
		else if (wr_hit(reg_wr_i, reg_addr_i, OFF_IRQ_EN_CLK))
			irq_en_clk_reg <= reg_wdata_i & MASK_IRQ_EN_CLK; // RULE_18
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			irq_en_pat_reg <= RST_IRQ_EN; // RULE_03
		else if (wr_hit(reg_wr_i, reg_addr_i, OFF_IRQ_EN_PAT))
			irq_en_pat_reg <= reg_wdata_i & MASK_IRQ_EN_PAT; // RULE_02
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			clk_rx_reg <= RST_CLK_RX; // RULE_13
		else if (wr_hit(reg_wr_i, reg_addr_i, OFF_CLK_RX))
			clk_rx_reg <= reg_wdata_i & MASK_CLK_RX; // RULE_13
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			pll_ctrl_reg <= RST_PLL_CTRL; // RULE_15
		else if (wr_hit(reg_wr_i, reg_addr_i, OFF_PLL_CTRL))
			pll_ctrl_reg <= reg_wdata_i & MASK_PLL_CTRL; // RULE_14
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			pll_loop_reg <= RST_PLL_LOOP; // RULE_16
		else if (wr_hit(reg_wr_i, reg_addr_i, OFF_PLL_LOOP))
			pll_loop_reg <= reg_wdata_i & MASK_PLL_LOOP; // RULE_17
	end

	assign irq_any = |(flags & {irq_en_pat_reg, irq_en_clk_reg}); // RULE_19

	// request follows the enabled flags one edge later
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			irq_reg <= 1'b0;
		else
			irq_reg <= irq_any; // RULE_19
	end

	always_comb
	begin
		rdata_next = '0;
		unique case (reg_addr_i)
			OFF_IRQ_EN_CLK: rdata_next = irq_en_clk_reg;
			OFF_IRQ_EN_PAT: rdata_next = irq_en_pat_reg;
			OFF_FLAGS_CLK: rdata_next = flags[DATA_W-1:0];
			OFF_FLAGS_PAT: rdata_next = flags[FLAG_W-1:DATA_W];
			OFF_CLK_RX: rdata_next = clk_rx_reg;
			OFF_PLL_CTRL: rdata_next = pll_ctrl_reg;
			OFF_PLL_LOOP: rdata_next = pll_loop_reg;
			default: rdata_next = '0;
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rdata_reg <= '0;
		else
			rdata_reg <= rdata_next;
	end

	assign reg_rdata_o = rdata_reg;
	assign irq_o = irq_reg;
	assign conv_duty_corr_o = clk_rx_reg[BIT_DUTY_CONV];
	assign ref_duty_corr_o = clk_rx_reg[BIT_DUTY_REF];
	assign conv_cross_corr_o = clk_rx_reg[BIT_CROSS_CONV];
	assign ref_cross_corr_o = clk_rx_reg[BIT_CROSS_REF];
	assign pll_enable_o = pll_ctrl_reg[BIT_PLL_EN];
	assign manual_band_en_o = pll_ctrl_reg[BIT_MAN_BAND_EN];
	assign manual_oscillator_band_o = pll_ctrl_reg[BAND_MSB:0];
	assign loop_bw_o = pll_loop_reg[BW_MSB:BW_LSB];
	assign charge_pump_o = pll_loop_reg[CP_MSB:0];

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);

	a_lock_lost_latch: assert property ( // RULE_04
		pll_locked_prev_reg && !pll_locked_i |=> flags[BIT_PLL_LOCK_LOST])
		else $error("lock lost flag not latched");

	a_locked_flag: assert property ( // RULE_05
		pll_locked_i |=> flags[BIT_PLL_LOCKED] && rdata_next[BIT_PLL_LOCKED] ||
			reg_addr_i != OFF_FLAGS_CLK)
		else $error("locked flag not set while locked");

	a_sync_lost_hold: assert property ( // RULE_06
		flags[BIT_SYNC_LOST] && !(reg_wr_i && reg_addr_i == OFF_FLAGS_CLK)
		|=> flags[BIT_SYNC_LOST])
		else $error("sync lost flag dropped without clear");

	a_sync_locked_set: assert property ( // RULE_07
		$rose(sync_aligned_i) |=> flags[BIT_SYNC_LOCKED])
		else $error("sync locked flag not set");

	a_fifo_warn_set: assert property ( // RULE_08
		fifo_gap_i == PTR_W'(FIFO_GAP_WARN2) |=> flags[BIT_FIFO_WARN2])
		else $error("fifo warning two not set");

	a_fifo_warn_one: assert property ( // RULE_08
		fifo_gap_i == PTR_W'(FIFO_GAP_WARN1) |=> flags[BIT_FIFO_WARN1])
		else $error("fifo warning one not set");

	a_w1c_clear: assert property ( // RULE_09
		reg_wr_i && reg_addr_i == OFF_FLAGS_PAT && reg_wdata_i[BIT_SMP_FAIL] && !smp_fail_i
		|=> !flags[DATA_W + BIT_SMP_FAIL])
		else $error("write one did not clear flag");

	a_w1c_zero_keeps: assert property ( // RULE_09
		reg_wr_i && reg_addr_i == OFF_FLAGS_PAT && !reg_wdata_i[BIT_AVG_PASS]
		&& flags[DATA_W + BIT_AVG_PASS] |=> flags[DATA_W + BIT_AVG_PASS])
		else $error("write zero changed flag");

	a_avg_pass_set: assert property ( // RULE_10
		avg_pass_i |=> flags[DATA_W + BIT_AVG_PASS])
		else $error("averaged pass flag not set");

	a_avg_autoclear: assert property ( // RULE_11
		avg_autoclr && !avg_fail_i |=> !flags[DATA_W + BIT_AVG_FAIL] && pair_cnt_reg == '0)
		else $error("averaged fail not self cleared");

	a_avg_count_eight: assert property ( // RULE_11
		avg_autoclr |-> pair_cnt_reg == PAIR_CNT_W'(AVG_CLEAR_PAIRS - 1))
		else $error("auto clear at wrong pair count");

	a_smp_fail_set: assert property ( // RULE_12
		smp_fail_i |=> flags[DATA_W + BIT_SMP_FAIL])
		else $error("sample fail flag not set");

	a_pll_en_write: assert property ( // RULE_14
		reg_wr_i && reg_addr_i == OFF_PLL_CTRL |=> pll_enable_o == $past(reg_wdata_i[BIT_PLL_EN])
		&& manual_oscillator_band_o == $past(reg_wdata_i[BAND_MSB:0]))
		else $error("pll control write not applied");

	a_loop_write: assert property ( // RULE_16
		reg_wr_i && reg_addr_i == OFF_PLL_LOOP |=> loop_bw_o == $past(reg_wdata_i[BW_MSB:BW_LSB])
		&& charge_pump_o == $past(reg_wdata_i[CP_MSB:0]))
		else $error("loop setting write not applied");

	a_irq_follow: assert property ( // RULE_19
		##1 irq_o == $past(irq_any))
		else $error("interrupt does not follow enabled flags");

	a_irq_pat_gate: assert property ( // RULE_02
		flags[DATA_W + BIT_AVG_FAIL] && irq_en_pat_reg[BIT_AVG_FAIL] |=> irq_o)
		else $error("enabled averaged fail gave no interrupt");

	c_irq_rise: cover property ($rose(irq_o));
	c_auto_clear: cover property (avg_autoclr);
	c_lock_lost: cover property (pll_locked_prev_reg && !pll_locked_i);
	c_set_and_clear: cover property (smp_fail_i && reg_wr_i && reg_addr_i == OFF_FLAGS_PAT
		&& reg_wdata_i[BIT_SMP_FAIL]);
endmodule

// ### dv/event_pll_regs_bench.sv
// self-checking bench for the event flag and pll register bank
module event_pll_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import evt_pll_pkg::*;

	typedef struct {
		logic [2:0] kind;
		logic [7:0] exp;
	} note_t;

	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [ADDR_W-1:0] reg_addr_i = 8'h00;
	logic [DATA_W-1:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic [8:0] src = 9'h000;
	logic [DATA_W-1:0] reg_rdata_o;
	logic irq_o;
	logic conv_duty_corr_o;
	logic ref_duty_corr_o;
	logic conv_cross_corr_o;
	logic ref_cross_corr_o;
	logic pll_enable_o;
	logic manual_band_en_o;
	logic [5:0] manual_oscillator_band_o;
	logic [1:0] loop_bw_o;
	logic [4:0] charge_pump_o;
	note_t notes[$];
	event chk_ev;
	int fail_count = 0;
	int total_checks = 0;
	int seed = 47218;
	logic [7:0] rnd;
	logic [7:0] offs [5];
	logic [7:0] masks [5];

	always #50 clock_i = ~clock_i;

	event_pll_regs #(.PTR_W(3)) DUT (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i),
		.reg_rdata_o(reg_rdata_o),
		.pll_locked_i(src[8]),
		.sync_aligned_i(src[7]),
		.fifo_gap_i(src[6:4]),
		.avg_pass_i(src[3]),
		.avg_fail_i(src[2]),
		.iq_pair_valid_i(src[1]),
		.smp_fail_i(src[0]),
		.irq_o(irq_o),
		.conv_duty_corr_o(conv_duty_corr_o),
		.ref_duty_corr_o(ref_duty_corr_o),
		.conv_cross_corr_o(conv_cross_corr_o),
		.ref_cross_corr_o(ref_cross_corr_o),
		.pll_enable_o(pll_enable_o),
		.manual_band_en_o(manual_band_en_o),
		.manual_oscillator_band_o(manual_oscillator_band_o),
		.loop_bw_o(loop_bw_o),
		.charge_pump_o(charge_pump_o)
	);

	// config outputs packed in their register layout
	function automatic logic [7:0] observe(input logic [2:0] kind);
		case (kind)
			3'd1: return {conv_duty_corr_o, ref_duty_corr_o, conv_cross_corr_o,
				ref_cross_corr_o, 4'h0};
			3'd2: return {pll_enable_o, manual_band_en_o, manual_oscillator_band_o};
			3'd3: return {loop_bw_o, 1'b0, charge_pump_o};
			default: return reg_rdata_o;
		endcase
	endfunction

	task automatic cmp_byte(input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic cmp_bit(input logic exp, input logic got);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t irq exp=%h got=%h", $time, exp, got);
		end
	endtask

	always @(chk_ev)
	begin
		note_t n;
		while (notes.size() > 0)
		begin
			n = notes.pop_front();
			if (n.kind == 3'd4)
				cmp_bit(n.exp[0], irq_o);
			else
				cmp_byte(n.exp, observe(n.kind));
		end
	end

	task automatic note_exp(input logic [2:0] kind, input logic [7:0] exp);
		notes.push_back('{kind, exp});
		->chk_ev;
	endtask

	// read data is registered from the address of the previous edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock_i);
		#1;
		reg_addr_i = a;
		@(posedge clock_i);
		#1;
		note_exp(3'd0, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		#1;
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(posedge clock_i);
		#1;
		reg_wr_i = 1'b0;
	endtask

	// {locked, aligned, gap[2:0], pass, fail, pair, sample fail}
	task automatic drive(input logic [8:0] v);
		@(posedge clock_i);
		#1;
		src = v;
	endtask

	// irq is registered behind the flag, so allow two edges
	task automatic irq_is(input logic e);
		repeat (2) @(posedge clock_i);
		#1;
		note_exp(3'd4, {7'h00, e});
	endtask

	task automatic conclude();
		#1;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		#100000;
		fail_count++;
		conclude();
	end

	initial
	begin
		offs = '{OFF_IRQ_EN_CLK, OFF_IRQ_EN_PAT, OFF_CLK_RX, OFF_PLL_CTRL, OFF_PLL_LOOP};
		masks = '{MASK_IRQ_EN_CLK, MASK_IRQ_EN_PAT, MASK_CLK_RX, MASK_PLL_CTRL, MASK_PLL_LOOP};
		repeat (4) @(posedge clock_i);
		#1;
		rstn_i = 1'b1;
		note_exp(3'd1, 8'h30);
		note_exp(3'd2, 8'h40);
		note_exp(3'd3, 8'hD1);
		rd(OFF_IRQ_EN_CLK, 8'h00);
		rd(OFF_IRQ_EN_PAT, 8'h00);
		rd(OFF_PLL_CTRL, 8'h40);
		rd(OFF_PLL_LOOP, 8'hD1);
		wr(8'h09, 8'hFF);
		rd(8'h09, 8'h00);
		for (int i = 0; i < 20; i++)
		begin
			rnd = 8'($random(seed));
			// unused pattern enable bits are always written as zero
			wr(offs[i % 5], (i % 5 == 1) ? rnd & MASK_IRQ_EN_PAT : rnd);
			rd(offs[i % 5], rnd & masks[i % 5]);
			if (i % 5 >= 2)
				note_exp(3'(i % 5 - 1), rnd & masks[i % 5]);
		end
		wr(OFF_IRQ_EN_CLK, 8'h00);
		wr(OFF_IRQ_EN_PAT, 8'h00);
		// lock and alignment, then both lost while the gap widens
		drive(9'h190);
		drive(9'h020);
		drive(9'h000);
		rd(OFF_FLAGS_CLK, 8'hF3);
		wr(OFF_FLAGS_CLK, 8'h81);
		rd(OFF_FLAGS_CLK, 8'h72);
		wr(OFF_FLAGS_CLK, 8'h00);
		rd(OFF_FLAGS_CLK, 8'h72);
		wr(OFF_IRQ_EN_CLK, 8'h02);
		irq_is(1'b1);
		wr(OFF_FLAGS_CLK, 8'h72);
		irq_is(1'b0);
		rd(OFF_FLAGS_CLK, 8'h00);
		// clearing while still locked: the set wins
		drive(9'h100);
		wr(OFF_FLAGS_CLK, 8'h40);
		rd(OFF_FLAGS_CLK, 8'h40);
		drive(9'h000);
		rd(OFF_FLAGS_CLK, 8'hC0);
		wr(OFF_FLAGS_CLK, 8'hC0);
		rd(OFF_FLAGS_CLK, 8'h00);
		wr(OFF_IRQ_EN_CLK, 8'h00);
		wr(OFF_IRQ_EN_PAT, 8'h04);
		drive(9'h001);
		drive(9'h000);
		irq_is(1'b1);
		rd(OFF_FLAGS_PAT, 8'h04);
		wr(OFF_FLAGS_PAT, 8'h04);
		irq_is(1'b0);
		// pass and fail set while masked, then unmasked
		drive(9'h00C);
		drive(9'h000);
		irq_is(1'b0);
		wr(OFF_IRQ_EN_PAT, 8'h18);
		irq_is(1'b1);
		rd(OFF_FLAGS_PAT, 8'h18);
		repeat (7)
		begin
			drive(9'h002);
			drive(9'h000);
		end
		rd(OFF_FLAGS_PAT, 8'h18);
		drive(9'h002);
		drive(9'h000);
		rd(OFF_FLAGS_PAT, 8'h10);
		wr(OFF_FLAGS_PAT, 8'h10);
		irq_is(1'b0);
		rd(OFF_FLAGS_PAT, 8'h00);
		conclude();
	end
endmodule
